// *** verilog/fcs_pkg.sv ***
package fcs_pkg;
    // ------------------------------------------------------------
    // Widths and timing
    // ------------------------------------------------------------
    localparam int ADDR_W     = 20;
    localparam int DATA_W     = 16;
    localparam int CLK_NS     = 10;
    localparam int T_SETUP_NS = 20;  // Address and chip select before strobe
    localparam int T_PULSE_NS = 40;  // Strobe low time
    localparam int T_HOLD_NS  = 20;  // Address and data after strobe rise
    localparam int SETUP_CYC  = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int PULSE_CYC  = (T_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int HOLD_CYC   = (T_HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W      = 4;

    // ------------------------------------------------------------
    // Addresses and command bytes
    // ------------------------------------------------------------
    localparam logic [19:0] UNLOCK_A1  = 20'h00555;
    localparam logic [19:0] UNLOCK_A2  = 20'h002aa;
    localparam logic [19:0] CFI_ADDR   = 20'h00055;
    localparam int          SECT_LSB   = 12;
    localparam logic [11:0] SECT_LOW   = 12'h000;
    localparam logic [3:0]  ID_PAD     = 4'h0;
    localparam logic [7:0]  CMD_UNLK1  = 8'haa;
    localparam logic [7:0]  CMD_UNLK2  = 8'h55;
    localparam logic [7:0]  CMD_ID     = 8'h90;
    localparam logic [7:0]  CMD_SECURE = 8'h88;
    localparam logic [7:0]  CMD_PROG   = 8'ha0;
    localparam logic [7:0]  CMD_BYPASS = 8'h20;
    localparam logic [7:0]  CMD_ERASE  = 8'h80;
    localparam logic [7:0]  CMD_CHIP   = 8'h10;
    localparam logic [7:0]  CMD_SECTOR = 8'h30;
    localparam logic [7:0]  CMD_SUSP   = 8'hb0;
    localparam logic [7:0]  CMD_RESUME = 8'h30;
    localparam logic [7:0]  CMD_RESET  = 8'hf0;
    localparam logic [7:0]  CMD_CFI    = 8'h98;
    localparam logic [7:0]  CMD_ZERO   = 8'h00;
    localparam logic [7:0]  UPPER_ZERO = 8'h00;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_READ, OP_RESET, OP_ID_READ, OP_SEC_ENTER, OP_SEC_EXIT, OP_CFI,
        OP_PROGRAM, OP_BYPASS_ENTER, OP_BYPASS_PROGRAM, OP_BYPASS_RESET,
        OP_CHIP_ERASE, OP_SECTOR_ERASE, OP_SUSPEND, OP_RESUME
    } fcs_op_t;

    typedef enum logic [2:0] {
        MD_READ, MD_ID, MD_CFI, MD_BYPASS, MD_SECURED, MD_ERASING, MD_SUSPEND
    } fcs_mode_t;

    typedef struct packed {
        fcs_op_t           op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } fcs_cmd_t;

    typedef struct packed {
        logic              ce_n;
        logic              we_n;
        logic              oe_n;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dq_out;
        logic              dq_oe;
    } fcs_pins_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic              rd;
        logic              last;
    } fcs_step_t;

    // Command byte in the low lane, upper lane driven as zero
    function automatic logic [DATA_W-1:0] fcs_cb(input logic [7:0] b);
        return {UPPER_ZERO, b};
    endfunction : fcs_cb

    // Bus cycle number i of the sequence for op
    function automatic fcs_step_t fcs_seq(input fcs_op_t op, input logic [2:0] i,
                                          input logic [ADDR_W-1:0] a,
                                          input logic [DATA_W-1:0] d);
        fcs_step_t   s;
        logic [19:0] sect;
        sect = {a[19:SECT_LSB], SECT_LOW};
        s = '{addr: UNLOCK_A1, data: fcs_cb(CMD_UNLK1), rd: 1'b0, last: 1'b0};
        unique case (op)
            OP_READ: s = '{addr: a, data: d, rd: 1'b1, last: 1'b1};
            OP_RESET: s = '{addr: UNLOCK_A1, data: fcs_cb(CMD_RESET), rd: 1'b0, last: 1'b1};
            OP_CFI: s = '{addr: CFI_ADDR, data: fcs_cb(CMD_CFI), rd: 1'b0, last: 1'b1};
            OP_SUSPEND: s = '{addr: UNLOCK_A1, data: fcs_cb(CMD_SUSP), rd: 1'b0, last: 1'b1};
            OP_RESUME: s = '{addr: UNLOCK_A1, data: fcs_cb(CMD_RESUME), rd: 1'b0, last: 1'b1};
            OP_BYPASS_PROGRAM: begin
                if (i == 3'd0) s.data = fcs_cb(CMD_PROG);
                else s = '{addr: a, data: d, rd: 1'b0, last: 1'b1};
            end
            OP_BYPASS_RESET: begin
                s.data = fcs_cb((i == 3'd0) ? CMD_ID : CMD_ZERO);
                s.last = (i != 3'd0);
            end
            default: begin
                unique case (i)
                    3'd0, 3'd3: s.data = fcs_cb(CMD_UNLK1);
                    3'd1, 3'd4: s = '{addr: UNLOCK_A2, data: fcs_cb(CMD_UNLK2),
                                      rd: 1'b0, last: 1'b0};
                    3'd2: begin
                        unique case (op)
                            OP_SEC_ENTER:    s.data = fcs_cb(CMD_SECURE);
                            OP_PROGRAM:      s.data = fcs_cb(CMD_PROG);
                            OP_BYPASS_ENTER: s.data = fcs_cb(CMD_BYPASS);
                            OP_CHIP_ERASE,
                            OP_SECTOR_ERASE: s.data = fcs_cb(CMD_ERASE);
                            default:         s.data = fcs_cb(CMD_ID);
                        endcase
                        s.last = (op == OP_SEC_ENTER) || (op == OP_BYPASS_ENTER);
                    end
                    default: ;
                endcase
                if (i == 3'd3) begin
                    s.last = 1'b1;
                    if (op == OP_ID_READ)
                        s = '{addr: {a[19:SECT_LSB], ID_PAD, a[7:0]}, data: d,
                              rd: 1'b1, last: 1'b1};
                    else if (op == OP_SEC_EXIT)
                        s.data = fcs_cb(CMD_ZERO);
                    else if (op == OP_PROGRAM)
                        s = '{addr: a, data: d, rd: 1'b0, last: 1'b1};
                    else
                        s.last = 1'b0;
                end
                if (i == 3'd5) begin
                    s.last = 1'b1;
                    if (op == OP_SECTOR_ERASE)
                        s = '{addr: sect, data: fcs_cb(CMD_SECTOR), rd: 1'b0, last: 1'b1};
                    else
                        s.data = fcs_cb(CMD_CHIP);
                end
            end
        endcase
        return s;
    endfunction : fcs_seq
endpackage : fcs_pkg

// *** verilog/fcs_host.sv ***
// Summary of operation
// - Sector chosen by address bits 19..12 only
// - All cycles write except reads, id fourth
// - Host issues F0 reset to leave id/timeout
// - Id entry AA,55,90 then read offsets 0-3
// - Program: AA,55,A0 then data at address
// - Host enters bypass before bypass programs
// - Erase six writes, 10 chip, 30 sector
// - Secured region: enter 88, exit 90,00
`timescale 1ns/1ns
module fcs_host (
    input  wire logic                   core_clk,
    input  wire logic                   rst,
    input  wire logic                   cmd_valid,
    output logic                        cmd_ready,
    input  wire fcs_pkg::fcs_cmd_t      cmd,
    output logic                        resp_valid,
    output logic                        resp_err,
    output logic [fcs_pkg::DATA_W-1:0]  resp_data,
    output fcs_pkg::fcs_pins_t          pins,
    input  wire logic [fcs_pkg::DATA_W-1:0] dq_in,
    input  wire logic                   ready_busy_n,
    output fcs_pkg::fcs_mode_t          mode,
    output logic                        flash_busy
);
    import fcs_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_PULSE, ST_HOLD} fcs_state_t;

    fcs_state_t       state;
    fcs_cmd_t         cur;
    logic [2:0]       idx;
    logic [CNT_W-1:0] cnt;
    logic             seen_busy;

    fcs_step_t        step;
    logic             legal;
    logic             take;
    logic             cnt_done;
    logic             emb_op;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    // Host only launches sequences the device would honour; the rest are refused
    // Chip erase stays out of the erasing mode
    always_comb begin
        unique case (cmd.op)
            OP_READ:           legal = (mode != MD_ERASING);
            OP_RESET:          legal = 1'b1;
            OP_ID_READ:        legal = (mode == MD_READ) || (mode == MD_ID)
                                       || (mode == MD_SUSPEND);
            OP_CFI:            legal = (mode == MD_READ) || (mode == MD_ID);
            OP_PROGRAM:        legal = (mode == MD_READ) || (mode == MD_SUSPEND);
            OP_BYPASS_ENTER:   legal = (mode == MD_READ);
            OP_BYPASS_PROGRAM: legal = (mode == MD_BYPASS);
            OP_BYPASS_RESET:   legal = (mode == MD_BYPASS);
            OP_SUSPEND:        legal = (mode == MD_ERASING);
            OP_RESUME:         legal = (mode == MD_SUSPEND);
            OP_SEC_EXIT:       legal = (mode == MD_SECURED);
            default:           legal = (mode == MD_READ);
        endcase
    end

    // Bus stays open in sector erase so suspend can go out
    assign take       = (state == ST_IDLE) && cmd_valid && !flash_busy;
    assign cmd_ready  = (state == ST_IDLE) && !flash_busy;
    assign cnt_done   = (cnt == '0);
    assign step       = fcs_seq(cur.op, idx, cur.addr, cur.data);
    assign flash_busy = !ready_busy_n && (mode != MD_ERASING);

    assign emb_op     = (cur.op == OP_PROGRAM) || (cur.op == OP_BYPASS_PROGRAM)
                        || (cur.op == OP_CHIP_ERASE) || (cur.op == OP_SECTOR_ERASE);

    // ------------------------------------------------------------
    // Bus cycle sequencer
    // ------------------------------------------------------------
    // Address set before the strobe falls and data held past its rise covers both edges
    // Whole-cycle timing is simple but slow
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state      <= ST_IDLE;
            cur        <= '{op: OP_READ, addr: '0, data: '0};
            idx        <= '0;
            cnt        <= '0;
            resp_valid <= 1'b0;
            resp_err   <= 1'b0;
            resp_data  <= '0;
            pins       <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: '0,
                            dq_out: '0, dq_oe: 1'b0};
        end else begin
            // One-cycle answer
            resp_valid <= 1'b0;
            unique case (state)
                // Refusals never touch the bus
                ST_IDLE: begin
                    if (take && legal) begin
                        cur   <= cmd;
                        idx   <= '0;
                        cnt   <= CNT_W'(SETUP_CYC - 1);
                        state <= ST_SETUP;
                    end else if (take) begin
                        resp_valid <= 1'b1;
                        resp_err   <= 1'b1;
                    end
                end

                // Select, address and data lead the strobe
                ST_SETUP: begin
                    pins.ce_n   <= 1'b0;
                    pins.addr   <= step.addr;
                    pins.dq_out <= step.data;
                    pins.dq_oe  <= !step.rd;
                    if (cnt_done) begin
                        cnt   <= CNT_W'(PULSE_CYC - 1);
                        state <= ST_PULSE;
                        pins.we_n <= step.rd;
                        pins.oe_n <= !step.rd;
                    end else begin
                        cnt <= cnt - 1'b1;
                    end
                end

                // Strobe low; read data taken at its end
                ST_PULSE: begin
                    if (cnt_done) begin
                        pins.we_n <= 1'b1;
                        pins.oe_n <= 1'b1;
                        if (step.rd) resp_data <= dq_in;
                        cnt   <= CNT_W'(HOLD_CYC - 1);
                        state <= ST_HOLD;
                    end else begin
                        cnt <= cnt - 1'b1;
                    end
                end

                // Hold, then release or start the next cycle
                ST_HOLD: begin
                    if (cnt_done) begin
                        pins.ce_n  <= 1'b1;
                        pins.dq_oe <= 1'b0;
                        if (step.last) begin
                            resp_valid <= 1'b1;
                            resp_err   <= 1'b0;
                            state      <= ST_IDLE;
                        end else begin
                            idx   <= idx + 1'b1;
                            cnt   <= CNT_W'(SETUP_CYC - 1);
                            state <= ST_SETUP;
                        end
                    end else begin
                        cnt <= cnt - 1'b1;
                    end
                end

                default: state <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Device mode tracking
    // ------------------------------------------------------------
    // Updated when a sequence ends; erase end seen as busy falling then released
    // Host view only; drifts if the device drops a command
    always_ff @(posedge core_clk) begin
        if (rst) begin
            mode      <= MD_READ;
            seen_busy <= 1'b0;
        end else begin
            if (!ready_busy_n) seen_busy <= 1'b1;

            // Only between sequences: a suspend write also raises ready
            if (mode == MD_ERASING && seen_busy && ready_busy_n
                && state == ST_IDLE) begin
                mode      <= MD_READ;
                seen_busy <= 1'b0;
            end

            // Mode follows the sequence that just ended
            if (state == ST_HOLD && cnt_done && step.last) begin
                if (emb_op) seen_busy <= 1'b0;

                unique case (cur.op)
                    OP_RESET:          mode <= (mode == MD_SUSPEND) ? MD_SUSPEND
                                               : MD_READ;
                    // Id from suspend keeps suspend, so reset returns there
                    OP_ID_READ:        mode <= (mode == MD_SUSPEND) ? MD_SUSPEND
                                               : MD_ID;
                    OP_CFI:            mode <= MD_CFI;
                    OP_SEC_ENTER:      mode <= MD_SECURED;
                    OP_SEC_EXIT:       mode <= MD_READ;
                    OP_BYPASS_ENTER:   mode <= MD_BYPASS;
                    OP_BYPASS_RESET:   mode <= MD_READ;
                    OP_SECTOR_ERASE:   mode <= MD_ERASING;
                    OP_SUSPEND:        mode <= MD_SUSPEND;
                    OP_RESUME:         mode <= MD_ERASING;
                    default:           mode <= mode;
                endcase
            end
        end
    end
endmodule : fcs_host

// *** tb/fcs_host_sva.sv ***
`timescale 1ns/1ns
module fcs_host_sva
    import fcs_pkg::*;
(
    input wire logic                   core_clk,
    input wire logic                   rst,
    input wire logic                   cmd_valid,
    input wire logic                   cmd_ready,
    input wire fcs_pkg::fcs_cmd_t      cmd,
    input wire logic                   resp_valid,
    input wire logic                   resp_err,
    input wire logic [15:0]            resp_data,
    input wire fcs_pkg::fcs_pins_t     pins,
    input wire logic [15:0]            dq_in,
    input wire logic                   ready_busy_n,
    input wire fcs_pkg::fcs_mode_t     mode,
    input wire logic                   flash_busy
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // Bus shape: select, strobes, who drives the data lines
    a_reset_idle: assert property (disable iff (1'b0)
        rst |=> pins.ce_n && pins.we_n && pins.oe_n && !pins.dq_oe && !resp_valid && mode == MD_READ)
        else $error("pins not idle after reset");
    a_strobe_excl: assert property (!(pins.we_n == 1'b0 && pins.oe_n == 1'b0))
        else $error("write and read strobes low together");
    a_strobe_select: assert property ((!pins.we_n || !pins.oe_n) |-> !pins.ce_n)
        else $error("strobe low without chip select");
    a_write_hold: assert property ((!pins.we_n && $past(!pins.we_n))
        |-> $stable(pins.addr) && $stable(pins.dq_out)) else $error("write moved under strobe");
    a_pulse_width: assert property ($fell(pins.we_n) |-> !pins.we_n [*4] ##1 pins.we_n)
        else $error("write strobe not four cycles");
    a_write_drive: assert property (!pins.we_n |-> pins.dq_oe)
        else $error("write strobe without data drive");
    a_read_release: assert property (!pins.oe_n |-> !pins.dq_oe)
        else $error("data driven during read");
    // Command cycles carry a zero upper byte
    a_cmd_upper: assert property ((!pins.we_n && (pins.addr == UNLOCK_A1 || pins.addr == UNLOCK_A2))
        |-> pins.dq_out[15:8] == 8'h00) else $error("upper byte set on command cycle");
    // Refusals and busy
    a_refuse_quiet: assert property (resp_valid && resp_err
        |-> pins.ce_n && $past(pins.ce_n)) else $error("bus activity on refused command");
    a_busy_block: assert property (flash_busy |-> !cmd_ready)
        else $error("request accepted while flash busy");
    a_no_overlap: assert property (!pins.ce_n |-> !cmd_ready)
        else $error("request accepted mid sequence");
endmodule : fcs_host_sva

bind fcs_host fcs_host_sva u_sva (
    .core_clk(core_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
    .resp_valid(resp_valid), .resp_err(resp_err), .resp_data(resp_data), .pins(pins),
    .dq_in(dq_in), .ready_busy_n(ready_busy_n), .mode(mode), .flash_busy(flash_busy)
);

// *** tb/fcs_flash_model.sv ***
`timescale 1ns/1ns
module fcs_flash_model #(
    parameter logic [15:0] MFR_CODE  = 16'h00a5,  // Arbitrary value
    parameter logic [15:0] DEV_CODE  = 16'h1234,  // Arbitrary value
    parameter logic [15:0] LOCK_CODE = 16'h0042,  // Arbitrary value
    parameter logic [7:0]  PROT_SECT = 8'h07
) (
    input  wire logic        ce_n,
    input  wire logic        we_n,
    input  wire logic        oe_n,
    input  wire logic [19:0] addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wdrive,
    output logic [15:0]      rdata,
    output logic             ready_busy_n
);
    logic [15:0]  mem [logic [19:0]];
    logic [19:0]  a_lat;
    logic [15:0]  rv = '0;
    logic [255:0] ersd = '0;
    logic [7:0]   erase_sect = '0;
    logic [2:0]   st = '0;
    logic         wr_act = 0, id = 0, cfi = 0, sec = 0, byp = 0, bx = 0;
    logic         susp = 0, ers = 0, chip = 0, prog_nx = 0;
    int           prog_left = 0, ers_left = 0;

    // Read data by mode; array default is a pattern of the address
    function automatic logic [15:0] rd_val(input logic [19:0] a);
        if (id) begin
            case (a[7:0])
                8'h00: return MFR_CODE;
                8'h01: return DEV_CODE;
                8'h02: return {15'h0, a[19:12] == PROT_SECT};
                default: return LOCK_CODE;
            endcase
        end
        if (cfi) return {8'h0c, a[7:0]};
        if (sec) return {8'h5e, a[7:0]};
        if (mem.exists(a)) return mem[a];
        if (ersd[a[19:12]]) return 16'hffff;
        return a[15:0] ^ 16'h3c5a;
    endfunction : rd_val

    // Decode one write; commands use the low byte and low 11 address bits, sector erase also bits 19..12
    task automatic wr(input logic [19:0] a, input logic [15:0] d);
        logic [7:0] b;
        logic       u1;
        b = d[7:0];
        u1 = (a[10:0] == 11'h555);
        if (prog_nx) begin
            mem[a] = d;
            prog_nx = 1'b0;
            prog_left = 20;
        end else if (b == 8'hf0) begin
            {id, cfi, byp, st} = '0;
        end else if (byp) begin
            prog_nx = (b == 8'ha0);
            if (bx && b == 8'h00) byp = 1'b0;
            bx = (b == 8'h90);
        end else if (b == 8'hb0 && ers && !chip) begin
            susp = 1'b1;
        end else if (b == 8'h30 && susp && st == 3'd0) begin
            susp = 1'b0;
        end else if (b == 8'h98 && a[10:0] == 11'h055 && st == 3'd0 && !ers && !susp) begin
            cfi = 1'b1;
        end else if (id && b == 8'h00) begin
            {id, sec} = '0;
        end else begin
            case (st)
                3'd0, 3'd3: st = (u1 && b == 8'haa) ? st + 3'd1 : 3'd0;
                3'd1, 3'd4: st = (a[10:0] == 11'h2aa && b == 8'h55) ? st + 3'd1 : 3'd0;
                3'd2: begin
                    st = (u1 && b == 8'h80) ? 3'd3 : 3'd0;
                    id = id || (u1 && b == 8'h90);
                    sec = sec || (u1 && b == 8'h88);
                    prog_nx = u1 && b == 8'ha0;
                    byp = u1 && b == 8'h20;
                end
                3'd5: begin
                    st = 3'd0;
                    chip = (b == 8'h10 && u1);
                    ers = chip || b == 8'h30;
                    erase_sect = a[19:12];
                    ers_left = 60;
                end
                default: st = 3'd0;
            endcase
        end
    endtask : wr

    // Address at later falling edge, data at first rising edge
    always @(negedge we_n or negedge ce_n) if (!we_n && !ce_n) begin
        a_lat = addr;
        wr_act = 1'b1;
    end
    always @(posedge we_n or posedge ce_n) if (wr_act) begin
        wr_act = 1'b0;
        if (wdrive) wr(a_lat, wdata);
    end

    // Released bus shows the inverse so stale data never matches
    always @(negedge oe_n) rv = rd_val(addr);
    assign rdata = (!ce_n && !oe_n) ? rv : ~rv;

    // Busy timers tick just after core clock rise, off the sampling window
    initial begin
        ready_busy_n = 1'b1;
        #7;
        forever begin
            #10;
            if (prog_left > 0) prog_left--;
            if (ers && !susp) ers_left--;
            if (ers && ers_left == 0) begin
                ers = 1'b0;
                if (chip) mem.delete();
                if (chip) ersd = '1;
                else ersd[erase_sect] = 1'b1;
            end
            ready_busy_n = !(prog_left > 0 || (ers && !susp));
        end
    end
endmodule : fcs_flash_model

// *** tb/fcs_host_tb.sv ***
`timescale 1ns/1ns
module fcs_host_tb;
    import fcs_pkg::*;
    localparam logic [15:0] MFR_CODE  = 16'h00a5;  // Arbitrary value
    localparam logic [15:0] DEV_CODE  = 16'h1234;  // Arbitrary value
    localparam logic [15:0] LOCK_CODE = 16'h0042;  // Arbitrary value
    localparam logic [7:0]  PROT_SECT = 8'h07;
    logic        core_clk, rst, cmd_valid, cmd_ready, resp_valid, resp_err, ready_busy_n;
    logic        flash_busy;
    fcs_cmd_t    cmd;
    fcs_pins_t   pins;
    fcs_mode_t   mode;
    logic [15:0] resp_data, dq_in, seed, pd;
    logic [19:0] pa;
    int          err_total = 0, tests_run = 0, cyc = 0;
    logic [19:0] id_a [5] = '{20'h07000, 20'h07001, 20'h07002, 20'h33002, 20'h55003};
    logic [15:0] id_e [5] = '{MFR_CODE, DEV_CODE, 16'h0001, 16'h0000, LOCK_CODE};
    fcs_op_t     bad [5] = '{OP_BYPASS_PROGRAM, OP_BYPASS_RESET, OP_SUSPEND, OP_RESUME, OP_SEC_EXIT};

    fcs_host dut (.core_clk(core_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd(cmd), .resp_valid(resp_valid), .resp_err(resp_err), .resp_data(resp_data),
        .pins(pins), .dq_in(dq_in), .ready_busy_n(ready_busy_n), .mode(mode),
        .flash_busy(flash_busy));
    fcs_flash_model #(.MFR_CODE(MFR_CODE), .DEV_CODE(DEV_CODE), .LOCK_CODE(LOCK_CODE),
        .PROT_SECT(PROT_SECT)) u_flash (.ce_n(pins.ce_n), .we_n(pins.we_n), .oe_n(pins.oe_n),
        .addr(pins.addr), .wdata(pins.dq_out), .wdrive(pins.dq_oe), .rdata(dq_in),
        .ready_busy_n(ready_busy_n));

    // Clock and hang guard
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            final_report();
        end
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    function automatic logic [15:0] exp_arr(input logic [19:0] a);
        return a[15:0] ^ 16'h3c5a;
    endfunction : exp_arr

    task automatic check_data(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected data at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_data
    task automatic check_state(input logic [3:0] got, input logic [3:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected state at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_state

    // Request held from a falling edge until taken; a hang meets the cycle guard
    task automatic send(input fcs_op_t op, input logic [19:0] a, input logic [15:0] d);
        @(negedge core_clk);
        while (cmd_ready !== 1'b1) @(negedge core_clk);
        cmd_valid = 1'b1;
        cmd = '{op: op, addr: a, data: d};
        @(negedge core_clk);
        cmd_valid = 1'b0;
        while (resp_valid !== 1'b1) @(negedge core_clk);
        @(negedge core_clk);
    endtask : send
    task automatic do_op(input fcs_op_t op, input logic [19:0] a, input logic e, input fcs_mode_t m);
        seed = lfsr(seed);
        send(op, a, seed);
        check_state({resp_err, mode}, {e, m});
    endtask : do_op
    task automatic rd(input logic [19:0] a, input logic [15:0] exp);
        seed = lfsr(seed);
        send(OP_READ, a, seed);
        check_data(resp_data, exp);
    endtask : rd
    task automatic prog(input fcs_op_t op, input fcs_mode_t m);
        seed = lfsr(seed);
        pa = {4'h8, seed};
        seed = lfsr(seed);
        pd = seed;
        send(op, pa, pd);
        check_state({resp_err, mode}, {1'b0, m});
    endtask : prog
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : final_report

    // Main sequence: reads, identification, bypass, refusals, secured region, erase
    initial begin
        rst = 1'b1;
        cmd_valid = 1'b0;
        cmd = '0;
        seed = 16'd13;
        repeat (3) @(negedge core_clk);
        rst = 1'b0;
        for (int i = 0; i < 8; i++) rd({4'h0, lfsr(seed)}, exp_arr({4'h0, lfsr(seed)}));
        for (int i = 0; i < 5; i++) begin
            do_op(OP_ID_READ, id_a[i], 1'b0, MD_ID);
            check_data(resp_data, id_e[i]);
        end
        do_op(OP_RESET, 20'h0, 1'b0, MD_READ);
        do_op(OP_CFI, 20'h0, 1'b0, MD_CFI);
        rd(20'h00012, 16'h0c12);
        do_op(OP_RESET, 20'h0, 1'b0, MD_READ);
        do_op(OP_BYPASS_ENTER, 20'h0, 1'b0, MD_BYPASS);
        do_op(OP_PROGRAM, 20'h0, 1'b1, MD_BYPASS);
        do_op(OP_CFI, 20'h0, 1'b1, MD_BYPASS);
        prog(OP_BYPASS_PROGRAM, MD_BYPASS);
        do_op(OP_BYPASS_RESET, 20'h0, 1'b0, MD_READ);
        rd(pa, pd);
        do_op(OP_BYPASS_ENTER, 20'h0, 1'b0, MD_BYPASS);
        do_op(OP_RESET, 20'h0, 1'b0, MD_READ);
        prog(OP_PROGRAM, MD_READ);
        rd(pa, pd);
        foreach (bad[i]) do_op(bad[i], 20'h0, 1'b1, MD_READ);
        do_op(OP_SEC_ENTER, 20'h0, 1'b0, MD_SECURED);
        rd(20'h00077, 16'h5e77);
        do_op(OP_SEC_EXIT, 20'h0, 1'b0, MD_READ);
        rd(20'h00077, exp_arr(20'h00077));
        do_op(OP_SECTOR_ERASE, 20'h2a123, 1'b0, MD_ERASING);
        check_data({8'h00, u_flash.erase_sect}, 16'h002a);
        do_op(OP_READ, 20'h0, 1'b1, MD_ERASING);
        do_op(OP_SUSPEND, 20'h0, 1'b0, MD_SUSPEND);
        rd(20'h01234, exp_arr(20'h01234));
        prog(OP_PROGRAM, MD_SUSPEND);
        rd(pa, pd);
        send(OP_ID_READ, 20'h0, seed);
        check_data(resp_data, MFR_CODE);
        do_op(OP_RESET, 20'h0, 1'b0, MD_SUSPEND);
        do_op(OP_RESUME, 20'h0, 1'b0, MD_ERASING);
        for (int n = 0; n < 300 && mode != MD_READ; n++) @(negedge core_clk);
        rd(20'h2a456, 16'hffff);
        do_op(OP_CHIP_ERASE, 20'h0, 1'b0, MD_READ);
        rd(pa, 16'hffff);
        final_report();
    end
endmodule : fcs_host_tb
